// file: src/rsts_pkg.sv
// Shared constants, types and register map of the reset sequencer
package rsts_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_FREQ_MHZ = 100;
    localparam real PWRUP_T0_US = 140.0;
    localparam real PWRUP_T1_MS = 4.5;
    localparam real PWRUP_T2_MS = 18.0;
    localparam real PWRUP_T3_MS = 72.0;
    localparam real PWRUP_T4_MS = 288.0;
    // Least times, so every count rounds up
    localparam int unsigned PWRUP_CYC0 = int'($ceil(PWRUP_T0_US * real'(CLK_FREQ_MHZ)));
    localparam int unsigned PWRUP_CYC1 = int'($ceil(PWRUP_T1_MS * 1000.0 * real'(CLK_FREQ_MHZ)));
    localparam int unsigned PWRUP_CYC2 = int'($ceil(PWRUP_T2_MS * 1000.0 * real'(CLK_FREQ_MHZ)));
    localparam int unsigned PWRUP_CYC3 = int'($ceil(PWRUP_T3_MS * 1000.0 * real'(CLK_FREQ_MHZ)));
    localparam int unsigned PWRUP_CYC4 = int'($ceil(PWRUP_T4_MS * 1000.0 * real'(CLK_FREQ_MHZ)));
    localparam int unsigned OSCW_CYCLES = 16;
    localparam int CNT_W = 25;
    localparam int SEL_W = 3;
    typedef logic [CNT_W-1:0] rsts_cnt_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte offsets within the slave
    localparam int ADDR_DEC_W = 8;
    localparam logic [ADDR_DEC_W-1:0] OFS_CONFIG = 8'h00;
    localparam logic [ADDR_DEC_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_DEC_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_DEC_W-1:0] OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [ADDR_DEC_W-1:0] OFS_IRQ_CLEAR = 8'h10;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Field layouts
    typedef struct packed {
        logic startup_slow;
        logic [SEL_W-1:0] pwrup_sel;
    } rsts_cfg_t;

    typedef struct packed {
        logic wdog;
        logic pin;
        logic lvd;
        logic por;
    } rsts_cause_t;

    typedef struct packed {
        logic pin_rst;
        logic wdog_rst;
        logic seq_done;
        logic rst_enter;
    } rsts_irq_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_PWRUP = 2'b01,
        ST_OSCW = 2'b10,
        ST_RUN = 2'b11
    } rsts_state_t;

    typedef struct packed {
        rsts_state_t state;
        logic run_slow;
        logic core_reset;
        logic powerdown_flag_n;
        logic timeout_flag_n;
    } rsts_status_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam rsts_cfg_t CFG_RESET = '{startup_slow: 1'h0, pwrup_sel: 3'h0};
    localparam rsts_irq_t IRQ_RESET = '{pin_rst: 1'h0, wdog_rst: 1'h0, seq_done: 1'h0, rst_enter: 1'h0};
    localparam logic FLAG_RESET = 1'h1;
    localparam logic PIN_SYNC_RESET = 1'h0;

endpackage : rsts_pkg

// file: src/rsts_sync.sv
// Two-flop level synchroniser, one chain per bit
module rsts_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;

    ////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stage1_q[i] <= RESET_VAL[i];
                sync_out[i] <= RESET_VAL[i];
            end else begin
                stage1_q[i] <= async_in[i];
                sync_out[i] <= stage1_q[i];
            end
        end
    end

endmodule : rsts_sync

// file: src/rsts_sequencer.sv
// Reset sequencer with timeout and power-down status flags, AHB-Lite registers
// Operation
// - Any of four causes enters reset state
// - Reset loads defined values, keeps undefined ones
// - External reset pin is active low
// - Power-on or low-voltage reset sets both flags
// - Pin reset outside halt keeps both flags
// - Pin reset in halt sets both flags
// - Watchdog reset outside halt: timeout 0, powerdown 1
// - Watchdog reset in halt clears both flags
// - Halt sets timeout, clears powerdown; clear sets both
// - Sequence starts only after all causes release
// - Wait selectable power-up time first
// - Power-up wait applies for every oscillator
// - Then count 16 oscillator cycles, release core
// - Start in fast or slow clock mode
//
// The AHB-Lite slave port and the register addresses were decided locally.
module rsts_sequencer #(
    parameter int unsigned PWRUP_CYC_0 = rsts_pkg::PWRUP_CYC0,
    parameter int unsigned PWRUP_CYC_1 = rsts_pkg::PWRUP_CYC1,
    parameter int unsigned PWRUP_CYC_2 = rsts_pkg::PWRUP_CYC2,
    parameter int unsigned PWRUP_CYC_3 = rsts_pkg::PWRUP_CYC3,
    parameter int unsigned PWRUP_CYC_4 = rsts_pkg::PWRUP_CYC4,
    parameter int unsigned OSCW_LEN = rsts_pkg::OSCW_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic por_detect,
    input wire logic low_voltage_reset,
    input wire logic external_reset_low,
    input wire logic watchdog_timer_timeout,
    input wire logic halt_mode,
    input wire logic halt_instruction,
    input wire logic watchdog_clear_instruction,
    output logic core_reset,
    output logic run_slow,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic irq
);

    rsts_pkg::rsts_state_t state_q;
    rsts_pkg::rsts_state_t state_d;
    rsts_pkg::rsts_cnt_t cnt_q;
    rsts_pkg::rsts_cnt_t pwrup_lim_q;
    rsts_pkg::rsts_cnt_t pwrup_lim_d;
    rsts_pkg::rsts_cause_t cause;
    rsts_pkg::rsts_cause_t cause_prev_q;
    rsts_pkg::rsts_cause_t cause_rise;
    rsts_pkg::rsts_cfg_t cfg_q;
    rsts_pkg::rsts_irq_t irq_sts_q;
    rsts_pkg::rsts_irq_t irq_en_q;
    rsts_pkg::rsts_irq_t irq_ev;
    rsts_pkg::rsts_status_t status;
    logic pin_sync_n;
    logic cause_any;
    logic cnt_last;
    logic core_reset_q;
    logic run_slow_q;
    logic to_q;
    logic pd_q;
    logic irq_q;
    logic addr_ok;
    logic wr_q;
    logic [rsts_pkg::ADDR_DEC_W-1:0] waddr_q;
    logic [31:0] rdata_d;
    logic [31:0] hrdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset causes

    // The pin may move at any time relative to hclk, so it crosses two flops
    rsts_sync #(
        .WIDTH(1),
        .RESET_VAL(rsts_pkg::PIN_SYNC_RESET)
    ) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(external_reset_low),
        .sync_out(pin_sync_n)
    );

    // Low on the pin is a reset request
    always_comb begin
        cause.por = por_detect;
        cause.lvd = low_voltage_reset;
        cause.pin = ~pin_sync_n;
        cause.wdog = watchdog_timer_timeout;
    end

    assign cause_any = |cause;
    assign cause_rise = cause & ~cause_prev_q;

    // Edge memory: a held cause is one event; the pin starts asserted, so no false edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_prev_q <= '{por: 1'h0, lvd: 1'h0, pin: ~rsts_pkg::PIN_SYNC_RESET, wdog: 1'h0};
        end else begin
            cause_prev_q <= cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine

    // Power-up limit; codes above the last choice fall back to the longest wait
    always_comb begin
        case (cfg_q.pwrup_sel)
            3'h0: pwrup_lim_d = rsts_pkg::rsts_cnt_t'(PWRUP_CYC_0);
            3'h1: pwrup_lim_d = rsts_pkg::rsts_cnt_t'(PWRUP_CYC_1);
            3'h2: pwrup_lim_d = rsts_pkg::rsts_cnt_t'(PWRUP_CYC_2);
            3'h3: pwrup_lim_d = rsts_pkg::rsts_cnt_t'(PWRUP_CYC_3);
            default: pwrup_lim_d = rsts_pkg::rsts_cnt_t'(PWRUP_CYC_4);
        endcase
    end

    // Last cycle of the running wait
    always_comb begin
        cnt_last = 1'b0;
        if (state_q == rsts_pkg::ST_PWRUP) begin
            cnt_last = (cnt_q == pwrup_lim_q - rsts_pkg::rsts_cnt_t'(1));
        end else if (state_q == rsts_pkg::ST_OSCW) begin
            cnt_last = (cnt_q == rsts_pkg::rsts_cnt_t'(OSCW_LEN - 1));
        end
    end

    // Any cause wins over every wait; the waits only start from a clean release
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rsts_pkg::ST_RESET: begin
                if (!cause_any) begin
                    state_d = rsts_pkg::ST_PWRUP;
                end
            end
            rsts_pkg::ST_PWRUP: begin
                if (cause_any) begin
                    state_d = rsts_pkg::ST_RESET;
                end else if (cnt_last) begin
                    state_d = rsts_pkg::ST_OSCW;
                end
            end
            rsts_pkg::ST_OSCW: begin
                if (cause_any) begin
                    state_d = rsts_pkg::ST_RESET;
                end else if (cnt_last) begin
                    state_d = rsts_pkg::ST_RUN;
                end
            end
            rsts_pkg::ST_RUN: begin
                if (cause_any) begin
                    state_d = rsts_pkg::ST_RESET;
                end
            end
        endcase
    end

    // State register; the power-up wait is never skipped for any oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= rsts_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Shared wait counter, cleared on every state change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (state_d != state_q || state_q == rsts_pkg::ST_RESET) begin
            cnt_q <= '0;
        end else if (state_q != rsts_pkg::ST_RUN) begin
            cnt_q <= cnt_q + rsts_pkg::rsts_cnt_t'(1);
        end
    end

    // Limit latched at release so a config write cannot stretch a running wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwrup_lim_q <= rsts_pkg::rsts_cnt_t'(PWRUP_CYC_4);
        end else if (state_q == rsts_pkg::ST_RESET && state_d == rsts_pkg::ST_PWRUP) begin
            pwrup_lim_q <= pwrup_lim_d;
        end
    end

    // Core held in reset, so its defined-value registers load; config keeps contents
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_reset_q <= 1'b1;
        end else begin
            core_reset_q <= (state_d != rsts_pkg::ST_RUN);
        end
    end

    // Clock mode picked when the core is let go
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_slow_q <= 1'b0;
        end else if (state_q == rsts_pkg::ST_OSCW && state_d == rsts_pkg::ST_RUN) begin
            run_slow_q <= cfg_q.startup_slow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timeout and power-down flags

    // Reset events outrank instructions; halt_mode is still valid in the event cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            to_q <= rsts_pkg::FLAG_RESET;
            pd_q <= rsts_pkg::FLAG_RESET;
        end else if (cause_rise.por || cause_rise.lvd) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (cause_rise.wdog) begin
            to_q <= 1'b0;
            pd_q <= ~halt_mode;
        end else if (cause_rise.pin) begin
            if (halt_mode) begin
                to_q <= 1'b1;
                pd_q <= 1'b1;
            end
        end else if (!core_reset_q && halt_instruction) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end else if (!core_reset_q && watchdog_clear_instruction) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    always_comb begin
        irq_ev.rst_enter = (state_q != rsts_pkg::ST_RESET) && (state_d == rsts_pkg::ST_RESET);
        irq_ev.seq_done = (state_q == rsts_pkg::ST_OSCW) && (state_d == rsts_pkg::ST_RUN);
        irq_ev.wdog_rst = cause_rise.wdog;
        irq_ev.pin_rst = cause_rise.pin;
    end

    // A new event in the clear cycle survives: set is applied after clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_sts_q <= rsts_pkg::IRQ_RESET;
        end else if (wr_q && waddr_q == rsts_pkg::OFS_IRQ_CLEAR) begin
            irq_sts_q <= (irq_sts_q & ~rsts_pkg::rsts_irq_t'(hwdata[3:0])) | irq_ev;
        end else begin
            irq_sts_q <= irq_sts_q | irq_ev;
        end
    end

    // Registered level output, one cycle behind the status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_sts_q & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY

    assign addr_ok = hsel && (htrans == rsts_pkg::HTRANS_NONSEQ) && hready;

    // Write is committed in the data phase when hwdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            waddr_q <= '0;
        end else begin
            wr_q <= addr_ok && hwrite;
            waddr_q <= haddr[rsts_pkg::ADDR_DEC_W-1:0];
        end
    end

    // Writable registers; they survive sequencer resets, only hresetn clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= rsts_pkg::CFG_RESET;
            irq_en_q <= rsts_pkg::IRQ_RESET;
        end else if (wr_q) begin
            if (waddr_q == rsts_pkg::OFS_CONFIG) begin
                cfg_q <= rsts_pkg::rsts_cfg_t'(hwdata[3:0]);
            end
            if (waddr_q == rsts_pkg::OFS_IRQ_ENABLE) begin
                irq_en_q <= rsts_pkg::rsts_irq_t'(hwdata[3:0]);
            end
        end
    end

    always_comb begin
        status.state = state_q;
        status.run_slow = run_slow_q;
        status.core_reset = core_reset_q;
        status.powerdown_flag_n = pd_q;
        status.timeout_flag_n = to_q;
    end

    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (haddr[rsts_pkg::ADDR_DEC_W-1:0])
            rsts_pkg::OFS_CONFIG: rdata_d = {28'h0000000, cfg_q};
            rsts_pkg::OFS_STATUS: rdata_d = {26'h0000000, status};
            rsts_pkg::OFS_IRQ_STATUS: rdata_d = {28'h0000000, irq_sts_q};
            rsts_pkg::OFS_IRQ_ENABLE: rdata_d = {28'h0000000, irq_en_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data sampled at the address phase, shown for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= rdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = rsts_pkg::HRESP_OKAY;
    assign hrdata = hrdata_q;
    assign core_reset = core_reset_q;
    assign run_slow = run_slow_q;
    assign timeout_flag_n = to_q;
    assign powerdown_flag_n = pd_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_cause_holds_reset: assert property (cause_any |=> core_reset_q && state_q == rsts_pkg::ST_RESET)
        else $error("core not held in reset by an active cause");
    a_por_sets_flags: assert property ((cause_rise.por || cause_rise.lvd) |=> to_q && pd_q)
        else $error("power-on reset did not set both flags");
    a_pin_run_keeps: assert property (cause_rise.pin && !halt_mode && !cause_rise.por && !cause_rise.lvd
        && !cause_rise.wdog |=> $stable(to_q) && $stable(pd_q))
        else $error("pin reset outside halt changed flags");
    a_pin_halt_sets: assert property (cause_rise.pin && halt_mode && !cause_rise.wdog |=> to_q && pd_q)
        else $error("pin reset in halt did not set flags");
    a_wdog_run_flags: assert property (cause_rise.wdog && !halt_mode && !cause_rise.por && !cause_rise.lvd
        |=> !to_q && pd_q)
        else $error("watchdog reset outside halt gave wrong flags");
    a_wdog_halt_flags: assert property (cause_rise.wdog && halt_mode && !cause_rise.por && !cause_rise.lvd
        |=> !to_q && !pd_q)
        else $error("watchdog reset in halt gave wrong flags");
    a_halt_instr_flags: assert property (halt_instruction && !core_reset_q && !(|cause_rise)
        |=> to_q && !pd_q)
        else $error("halt instruction gave wrong flags");
    a_clear_instr_flags: assert property (watchdog_clear_instruction && !halt_instruction && !core_reset_q
        && !(|cause_rise) |=> to_q && pd_q)
        else $error("watchdog clear gave wrong flags");
    a_release_waits: assert property (state_q == rsts_pkg::ST_RESET && cause_any
        |=> state_q == rsts_pkg::ST_RESET)
        else $error("sequence left reset with a cause active");
    a_pwrup_before_oscw: assert property ($rose(state_q == rsts_pkg::ST_OSCW)
        |-> $past(state_q == rsts_pkg::ST_PWRUP) && $past(cnt_q) == pwrup_lim_q - rsts_pkg::rsts_cnt_t'(1))
        else $error("start-up count began before power-up wait ended");
    a_oscw_length: assert property ($rose(state_q == rsts_pkg::ST_RUN)
        |-> $past(state_q == rsts_pkg::ST_OSCW, 16) && $past(state_q == rsts_pkg::ST_PWRUP, 17))
        else $error("start-up count not sixteen cycles");
    a_run_clock_mode: assert property ($rose(state_q == rsts_pkg::ST_RUN)
        |-> run_slow_q == $past(cfg_q.startup_slow) && !core_reset_q)
        else $error("wrong start clock mode or core still in reset");
    a_restart_waits: assert property ((state_q == rsts_pkg::ST_PWRUP || state_q == rsts_pkg::ST_OSCW)
        && cause_any |=> state_q == rsts_pkg::ST_RESET && cnt_q == '0)
        else $error("reasserted cause did not restart the sequence");
    a_pin_sync_delay: assert property (!external_reset_low [*2] |=> cause.pin)
        else $error("pin reset not seen two cycles after going low");

    c_full_sequence: cover property ($rose(state_q == rsts_pkg::ST_RUN));
    c_wdog_in_halt: cover property (cause_rise.wdog && halt_mode);
    c_restart_pwrup: cover property (state_q == rsts_pkg::ST_PWRUP && cause.pin);
    c_halt_instr: cover property (halt_instruction && !core_reset_q);

endmodule : rsts_sequencer

// file: verification/rsts_core_pin_model.sv
// Behavioural core and reset-pin driver facing the sequencer
module rsts_core_pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic core_reset,
    input wire logic pin_hold,
    input wire logic do_halt,
    input wire logic do_clear,
    output logic external_reset_low,
    output logic halt_mode,
    output logic halt_instruction,
    output logic watchdog_clear_instruction
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin has a pull-up, so a released pin reads high and a held one low
    assign external_reset_low = ~pin_hold;

    ////////////////////////////////////////////////////////////
    // Core issues instructions only while running and awake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_mode <= 1'h0;
            halt_instruction <= 1'h0;
            watchdog_clear_instruction <= 1'h0;
        end else begin
            halt_instruction <= do_halt & ~core_reset & ~halt_mode;
            watchdog_clear_instruction <= do_clear & ~core_reset & ~halt_mode;
            // Any reset wakes the core, one edge after the cause is taken
            halt_mode <= ~core_reset & (halt_mode | halt_instruction);
        end
    end
endmodule : rsts_core_pin_model

// file: verification/reset_sequencer_with_status_flags_tb.sv
// Self-checking bench: sequencing, status flags, registers and interrupt
module reset_sequencer_with_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PW [5] = '{20, 30, 40, 50, 60};
    // Cause or instruction per step, then expected timeout and power-down flags
    localparam logic [5:0] SM [9] = '{6'h04, 6'h08, 6'h10, 6'h04, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
    localparam logic [1:0] SE [9] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h2, 2'h3, 2'h1, 2'h3};
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] ev = 6'h0;
    logic hreadyout, hresp, core_reset, run_slow, timeout_flag_n, powerdown_flag_n, irq;
    logic ext_pin, halt_mode, halt_ins, clr_ins;
    logic [31:0] hrdata;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    // 100 MHz clock
    always #5 hclk = ~hclk;

    rsts_sequencer #(.PWRUP_CYC_0(PW[0]), .PWRUP_CYC_1(PW[1]), .PWRUP_CYC_2(PW[2]), .PWRUP_CYC_3(PW[3]),
        .PWRUP_CYC_4(PW[4]), .OSCW_LEN(16)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .por_detect(ev[0]), .low_voltage_reset(ev[1]), .external_reset_low(ext_pin),
        .watchdog_timer_timeout(ev[2]), .halt_mode(halt_mode), .halt_instruction(halt_ins),
        .watchdog_clear_instruction(clr_ins), .core_reset(core_reset), .run_slow(run_slow),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n), .irq(irq));

    rsts_core_pin_model core (.hclk(hclk), .hresetn(hresetn), .core_reset(core_reset), .pin_hold(ev[3]),
        .do_halt(ev[4]), .do_clear(ev[5]), .external_reset_low(ext_pin), .halt_mode(halt_mode),
        .halt_instruction(halt_ins), .watchdog_clear_instruction(clr_ins));

    ////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single AHB-Lite transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= rsts_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'h1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'h0, a, 32'h0, x);
        chk(x, e);
    endtask : rd_chk

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask : tick

    // Raise the masked sources for len edges, then drop them
    task automatic fire(input logic [5:0] m, input int len);
        @(posedge hclk);
        ev <= ev | m;
        repeat (len) @(posedge hclk);
        ev <= ev & ~m;
    endtask : fire

    // Edges from the release until the core runs, bounded
    task automatic wait_run(output int k);
        k = 0;
        do begin
            @(posedge hclk);
            #1;
            k++;
        end while (core_reset !== 1'h0 && k < 1000);
        // A core that never runs is a mismatch, whatever the caller checks
        if (core_reset !== 1'h0) begin
            miscompares++;
            $display("Error at %0t: core never released", $time);
        end
    endtask : wait_run

    task automatic step(input logic [5:0] m, input logic [1:0] e);
        fire(m, m[3] ? 4 : 1);
        #1;
        if (m[4] | m[5]) tick(4);
        else begin
            chk(32'(core_reset), 32'h1);
            wait_run(n);
        end
        chk(32'({timeout_flag_n, powerdown_flag_n}), 32'(e));
    endtask : step

    // Hang guard, well above the expected run length
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge hclk);
        #1;
        chk(32'({timeout_flag_n, powerdown_flag_n, core_reset, irq}), 32'he);
        @(posedge hclk);
        hresetn <= 1'h1;
        wait_run(n);
        chk(32'(n < 1000), 32'h1);
        rd_chk(rsts_pkg::OFS_CONFIG, 32'h0);
        rd_chk(rsts_pkg::OFS_IRQ_ENABLE, 32'h0);
        rd_chk(8'h20, 32'h0);
        rd_chk(rsts_pkg::OFS_IRQ_CLEAR, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("reset values done");
        // Power-up selects 0 to 4 and fallback code 7, with the start-up clock mode alternating
        for (int i = 0; i < 6; i++) begin
            wr(rsts_pkg::OFS_CONFIG, {28'h0, i[0], (i == 5) ? 3'h7 : i[2:0]});
            fire(6'h01, 1);
            wait_run(n);
            chk(32'(n), 32'(PW[(i == 5) ? 4 : i] + 17));
            chk(32'(run_slow), 32'(i[0]));
        end
        rd_chk(rsts_pkg::OFS_CONFIG, 32'hf);
        wr(rsts_pkg::OFS_STATUS, 32'h0);
        rd_chk(rsts_pkg::OFS_STATUS, 32'h3b);
        wr(rsts_pkg::OFS_CONFIG, 32'h0);
        $display("power-up timing done");
        for (int i = 0; i < 9; i++) step(SM[i], SE[i]);
        $display("status flags done");
        // Reassert once in the power-up wait, once in the start-up count
        for (int d = 10; d <= 30; d += 20) begin
            fire(6'h01, 1);
            repeat (d) @(posedge hclk);
            fire(6'h01, 1);
            wait_run(n);
            chk(32'(n), 32'(PW[0] + 17));
        end
        @(posedge hclk);
        ev <= 6'h02;
        fire(6'h01, 50);
        tick(30);
        chk(32'(core_reset), 32'h1);
        fire(6'h02, 1);
        wait_run(n);
        chk(32'(n), 32'(PW[0] + 17));
        @(posedge hclk);
        ev <= 6'h08;
        tick(1);
        chk(32'(core_reset), 32'h0);
        fire(6'h08, 3);
        wait_run(n);
        $display("release ordering done");
        // Only the watchdog event is enabled onto the interrupt line
        wr(rsts_pkg::OFS_IRQ_CLEAR, 32'hf);
        wr(rsts_pkg::OFS_IRQ_ENABLE, 32'h4);
        rd_chk(rsts_pkg::OFS_IRQ_ENABLE, 32'h4);
        fire(6'h01, 1);
        wait_run(n);
        chk(32'(irq), 32'h0);
        rd_chk(rsts_pkg::OFS_IRQ_STATUS, 32'h3);
        fire(6'h04, 1);
        tick(3);
        chk(32'(irq), 32'h1);
        wait_run(n);
        rd_chk(rsts_pkg::OFS_IRQ_STATUS, 32'h7);
        wr(rsts_pkg::OFS_IRQ_CLEAR, 32'h7);
        tick(2);
        chk(32'(irq), 32'h0);
        rd_chk(rsts_pkg::OFS_IRQ_STATUS, 32'h0);
        fire(6'h08, 3);
        wait_run(n);
        rd_chk(rsts_pkg::OFS_IRQ_STATUS, 32'hb);
        $display("interrupt done");
        final_report();
    end
endmodule : reset_sequencer_with_status_flags_tb
